//--- sclsup_pkg.sv
// Shared constants and types for the serial command-loss supervisor
package sclsup_pkg;
  // Clock and timing
  localparam int          CLK_HZ_DEF   = 200_000_000;  // hclk rate
  localparam int          WAIT_UNIT_MS = 100;          // wait time step 0.1 s
  localparam int          TICK_CYC_DEF = CLK_HZ_DEF / 1000 * WAIT_UNIT_MS;
  localparam logic [10:0] WAIT_MIN     = 11'h001;      // 0.1 s
  localparam logic [10:0] WAIT_MAX     = 11'h4B0;      // 120 s
  localparam logic [10:0] WAIT_RST     = 11'h00A;      // 1.0 s
  // Bit rates
  localparam int          BAUD_1200    = 1200;
  localparam int          BAUD_2400    = 2400;
  localparam int          BAUD_4800    = 4800;
  localparam int          BAUD_9600    = 9600;
  localparam int          BAUD_19200   = 19200;
  localparam logic [2:0]  BAUD_RST     = 3'h3;         // 9600 bit/s
  // Selector codes
  localparam logic [3:0]  FS_VOLT_A    = 4'h2;         // voltage, first minimum
  localparam logic [3:0]  FS_VOLT_B    = 4'h3;         // voltage, second minimum
  localparam logic [3:0]  FS_CURR      = 4'h5;         // current input
  localparam logic [3:0]  FS_VOLT_CURR = 4'h6;         // voltage plus current
  localparam logic [3:0]  FS_SERIAL    = 4'h7;         // serial port
  localparam logic [1:0]  RS_SERIAL    = 2'h3;         // run from serial port
  localparam logic [4:0]  MF_CMD_LOSS  = 5'h0B;        // output function 11
  localparam logic [4:0]  MO_SEL_RST   = 5'h0C;
  localparam logic [4:0]  RELAY_RST    = 5'h11;
  localparam logic [7:0]  STATION_RST  = 8'h01;
  // Register byte offsets
  localparam logic [7:0]  A_PROTO   = 8'h00;
  localparam logic [7:0]  A_BAUD    = 8'h04;
  localparam logic [7:0]  A_STATION = 8'h08;
  localparam logic [7:0]  A_RUNSRC  = 8'h0C;
  localparam logic [7:0]  A_FRQSRC  = 8'h10;
  localparam logic [7:0]  A_CRIT    = 8'h14;
  localparam logic [7:0]  A_ACTION  = 8'h18;
  localparam logic [7:0]  A_WAIT    = 8'h1C;
  localparam logic [7:0]  A_MOSEL   = 8'h20;
  localparam logic [7:0]  A_RLYSEL  = 8'h24;
  localparam logic [7:0]  A_VMIN    = 8'h28;
  localparam logic [7:0]  A_VMINB   = 8'h2C;
  localparam logic [7:0]  A_IMIN    = 8'h30;
  localparam logic [7:0]  A_PRESET  = 8'h34;
  localparam logic [7:0]  A_SERFRQ  = 8'h38;
  localparam logic [7:0]  A_SERCTL  = 8'h3C;
  localparam logic [7:0]  A_TXDATA  = 8'h40;
  localparam logic [7:0]  A_RXDATA  = 8'h44;
  localparam logic [7:0]  A_STATUS  = 8'h48;
  localparam logic [7:0]  A_INTSTAT = 8'h4C;
  localparam logic [7:0]  A_INTMASK = 8'h50;
  // Interrupt bit positions
  localparam int          IB_RX     = 0;
  localparam int          IB_TXDONE = 1;
  localparam int          IB_LOSS   = 2;
  localparam int          IB_FRMERR = 3;
  // Loss actions
  typedef enum logic [1:0] {
    SCLSUP_ACT_KEEP, SCLSUP_ACT_FREERUN, SCLSUP_ACT_DECEL, SCLSUP_ACT_PRESET
  } sclsup_act_t;
endpackage : sclsup_pkg

//--- sclsup_ser_if.sv
// Link between the core and its serial transmitter and receiver
`timescale 1ns/100ps
interface sclsup_ser_if;
  logic [17:0] bit_cyc;   // Clocks per bit
  logic        two_stop;  // Two stop bits when set
  logic [7:0]  tx_data;   // Character to send
  logic        tx_start;  // Start pulse
  logic        tx_busy;   // Transmitter busy
  logic        tx_done;   // Pulse in last cycle of final stop bit
  logic [7:0]  rx_data;   // Received character
  logic        rx_valid;  // Pulse with rx_data
  logic        rx_err;    // Pulse on bad stop bit
  modport core (output bit_cyc, two_stop, tx_data, tx_start,
                input tx_busy, tx_done, rx_data, rx_valid, rx_err);
  modport tx (input bit_cyc, two_stop, tx_data, tx_start, output tx_busy, tx_done);
  modport rx (input bit_cyc, output rx_data, rx_valid, rx_err);
endinterface : sclsup_ser_if

//--- sclsup_tx.sv
// Serial character transmitter with line-driver enable
`timescale 1ns/100ps
module sclsup_tx
  import sclsup_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  sclsup_ser_if.tx   ser,
  output logic       ser_out,
  output logic       ser_oe
);
  typedef enum logic [1:0] {SCLSUP_TX_IDLE, SCLSUP_TX_SHIFT} sclsup_txst_t;
  sclsup_txst_t st_ff;       // State
  logic [17:0]  cyc_ff;      // Cycles within bit
  logic [3:0]   bit_ff;      // Bit index in frame
  logic [10:0]  sh_ff;       // Frame shift register
  logic [3:0]   last_bit;    // Index of final stop bit
  logic         bit_end;     // Current bit time over

  assign last_bit = ser.two_stop ? 4'hA : 4'h9;
  assign bit_end  = (cyc_ff == ser.bit_cyc - 18'h00001);
  assign ser.tx_busy = (st_ff == SCLSUP_TX_SHIFT);
  // R17: driver only during frame
  assign ser_oe   = (st_ff == SCLSUP_TX_SHIFT);
  assign ser_out  = (st_ff == SCLSUP_TX_SHIFT) ? sh_ff[0] : 1'b1;
  assign ser.tx_done = ser.tx_busy && bit_end && (bit_ff == last_bit);

  // Frame sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff  <= SCLSUP_TX_IDLE;
      cyc_ff <= 18'h00000;
      bit_ff <= 4'h0;
      sh_ff  <= 11'h7FF;
    end
    else
    begin
      unique case (st_ff)
        SCLSUP_TX_IDLE:
        begin
          // R16: start, 8 data LSB first, stops
          if (ser.tx_start)
          begin
            st_ff  <= SCLSUP_TX_SHIFT;
            sh_ff  <= {2'b11, ser.tx_data, 1'b0};
            cyc_ff <= 18'h00000;
            bit_ff <= 4'h0;
          end
        end
        SCLSUP_TX_SHIFT:
        begin
          if (!bit_end)
            cyc_ff <= cyc_ff + 18'h00001;
          // R17: release right after last stop
          else if (bit_ff == last_bit)
            st_ff <= SCLSUP_TX_IDLE;
          else
          begin
            cyc_ff <= 18'h00000;
            bit_ff <= bit_ff + 4'h1;
            sh_ff  <= {1'b1, sh_ff[10:1]};
          end
        end
      endcase
    end
  end
endmodule : sclsup_tx

//--- sclsup_rx.sv
// Serial character receiver, mid-bit sampling
`timescale 1ns/100ps
module sclsup_rx
  import sclsup_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  sclsup_ser_if.rx   ser,
  input  wire logic  ser_in
);
  typedef enum logic [1:0] {SCLSUP_RX_IDLE, SCLSUP_RX_BITS} sclsup_rxst_t;
  sclsup_rxst_t st_ff;     // State
  logic [17:0]  cyc_ff;    // Cycles to next sample
  logic [3:0]   bit_ff;    // Samples taken
  logic [7:0]   sh_ff;     // Data shift register
  logic         samp;      // Sample point reached
  logic         stop_bit;  // Sample is the stop bit

  assign samp     = (st_ff == SCLSUP_RX_BITS) && (cyc_ff == 18'h00000);
  assign stop_bit = (bit_ff == 4'h9);
  assign ser.rx_valid = samp && stop_bit && ser_in;
  assign ser.rx_err   = samp && stop_bit && !ser_in;
  assign ser.rx_data  = sh_ff;

  // Start detect, then one sample per bit; only one stop bit checked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff  <= SCLSUP_RX_IDLE;
      cyc_ff <= 18'h00000;
      bit_ff <= 4'h0;
      sh_ff  <= 8'h00;
    end
    else
    begin
      unique case (st_ff)
        SCLSUP_RX_IDLE:
        begin
          // First sample lands mid start bit
          if (!ser_in)
          begin
            st_ff  <= SCLSUP_RX_BITS;
            cyc_ff <= {1'b0, ser.bit_cyc[17:1]};
            bit_ff <= 4'h0;
          end
        end
        SCLSUP_RX_BITS:
        begin
          if (!samp)
            cyc_ff <= cyc_ff - 18'h00001;
          // False start: line back high mid start bit
          else if (bit_ff == 4'h0 && ser_in)
            st_ff <= SCLSUP_RX_IDLE;
          else if (stop_bit)
            st_ff <= SCLSUP_RX_IDLE;
          else
          begin
            cyc_ff <= ser.bit_cyc - 18'h00001;
            bit_ff <= bit_ff + 4'h1;
            // R16: data arrives LSB first
            if (bit_ff != 4'h0)
              sh_ff <= {ser_in, sh_ff[7:1]};
          end
        end
      endcase
    end
  end
endmodule : sclsup_rx

//--- sclsup_top.sv
// Command-loss supervisor with serial port and AHB-Lite registers
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
// Function
// R1: supervise analog and serial frequency references
// R2: criterion 0 off, 1 half-min, 2 min
// R3: combined source: either input below minimum
// R4: after wait apply keep/freerun/decel/preset
// R5: preset action switches to preset frequency
// R6: output function 11 shows command loss
// R7: serial loss action defaults to 0
// R8: serial loss timeout defaults 1.0 s
// R9: five bit rates, default code 3
// R10: two stops Modbus, one stop ASCII
// R11: protocol 0 Modbus, 1 ASCII
// R12: unique station 1..250, own frames only; station_ff is stored unchecked and no frame is filtered by station
// R13: run source 3 takes serial run
// R14: frequency source 7 takes serial frequency
// R15: at most 16 drives per segment
// R16: start, 8 data LSB first, no parity
// R17: driver on only while transmitting
// R18: wait 0.1..120 s, default 1.0
module sclsup_top
  import sclsup_pkg::*;
#(
  parameter int CLK_HZ   = CLK_HZ_DEF,   // Shorten to speed up bit times
  parameter int TICK_CYC = TICK_CYC_DEF  // Cycles per 0.1 s wait step
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ser_in,
  output logic             ser_out,
  output logic             ser_oe,
  input  wire logic [11:0] analog_voltage_input,
  input  wire logic [11:0] analog_current_input,
  input  wire logic        run_input,
  input  wire logic [15:0] freq_cmd_input,
  output logic [15:0]      drive_freq,
  output logic             drive_run,
  output logic             output_cut,
  output logic             decel_stop,
  output logic             multifunc_output_pin,
  output logic             multifunc_relay_contact,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic        proto_ff;                  // 0 Modbus-RTU, 1 ASCII
  logic [2:0]  baud_ff;                   // Bit rate code
  logic [7:0]  station_ff;                // Station number
  logic [1:0]  run_command_source_ff;     // Run source
  logic [3:0]  freq_source_code_ff;       // Frequency source
  logic [1:0]  loss_criterion_select_ff;  // Analog loss criterion
  logic [1:0]  loss_action_select_ff;     // Action on loss
  logic [10:0] loss_wait_time_ff;         // Wait, 0.1 s steps
  logic [4:0]  multifunc_output_select_ff;
  logic [4:0]  multifunc_relay_select_ff;
  logic [11:0] voltage_input_min_ff;
  logic [11:0] voltage_input_min_b_ff;
  logic [11:0] current_input_min_ff;
  logic [15:0] preset_freq_ff;            // Lost-preset frequency
  logic [15:0] ser_freq_ff;               // Frequency from serial
  logic        ser_run_ff;                // Run from serial
  logic [7:0]  rx_data_ff;                // Last received character
  logic [3:0]  int_stat_ff;               // Sticky events
  logic [3:0]  int_mask_ff;               // Event enables
  // Bus state
  logic        wr_pend_ff;                // Write data phase next
  logic [7:0]  wr_addr_ff;                // Latched write offset
  logic [31:0] hrdata_ff;                 // Read data
  // Supervisor state
  logic [31:0] tick_ff;                   // Cycles within wait step
  logic [10:0] wait_cnt_ff;               // Elapsed wait steps
  logic        loss_ff;                   // Loss in effect
  logic [15:0] last_freq_ff;              // Frequency before loss
  logic [15:0] drive_freq_ff;
  logic        drive_run_ff;

  sclsup_ser_if ser ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire         addr_ph  = hsel && htrans[1] && hready;
  wire         wr_ph    = wr_pend_ff;
  wire [7:0]   rd_addr  = haddr[7:0];
  wire         wr_proto = wr_ph && (wr_addr_ff == A_PROTO);
  wire         wr_txd   = wr_ph && (wr_addr_ff == A_TXDATA);
  wire         wr_ctl   = wr_ph && (wr_addr_ff == A_SERCTL);
  wire         cmd_kick = wr_ctl && hwdata[1];  // Valid command seen
  wire [3:0]   int_clr  = (wr_ph && (wr_addr_ff == A_INTSTAT)) ? hwdata[3:0] : 4'h0;
  wire [10:0]  wait_wr  = (hwdata[10:0] < WAIT_MIN) ? WAIT_MIN :
                          (hwdata[10:0] > WAIT_MAX) ? WAIT_MAX : hwdata[10:0];

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  logic [17:0] bit_cyc;
  // R9: bit time from rate code
  always_comb
  begin
    unique case (baud_ff)
      3'h0:    bit_cyc = 18'(CLK_HZ / BAUD_1200);
      3'h1:    bit_cyc = 18'(CLK_HZ / BAUD_2400);
      3'h2:    bit_cyc = 18'(CLK_HZ / BAUD_4800);
      3'h4:    bit_cyc = 18'(CLK_HZ / BAUD_19200);
      default: bit_cyc = 18'(CLK_HZ / BAUD_9600);  // Codes 3, 5..7
    endcase
  end
  assign ser.bit_cyc  = bit_cyc;
  // R10: stop count follows protocol
  // R11: protocol 0 picks two stops
  assign ser.two_stop = !proto_ff;
  assign ser.tx_data  = hwdata[7:0];
  // Write while busy is dropped
  assign ser.tx_start = wr_txd && !ser.tx_busy;

  sclsup_tx u_tx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ser     (ser.tx),
    .ser_out (ser_out),
    .ser_oe  (ser_oe)
  );
  sclsup_rx u_rx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ser     (ser.rx),
    .ser_in  (ser_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loss detection
  function automatic logic below(input logic [11:0] x, input logic [11:0] mn,
                                 input logic [1:0] crit);
    // R2: half minimum or minimum
    below = (crit == 2'h1) ? (x < {1'b0, mn[11:1]}) :
            (crit == 2'h2) ? (x < mn) : 1'b0;
  endfunction : below

  wire v_low_a = below(analog_voltage_input, voltage_input_min_ff, loss_criterion_select_ff);
  wire v_low_b = below(analog_voltage_input, voltage_input_min_b_ff, loss_criterion_select_ff);
  wire i_low   = below(analog_current_input, current_input_min_ff, loss_criterion_select_ff);
  wire ser_src = (freq_source_code_ff == FS_SERIAL);
  // R1: sources under supervision
  // R3: combined source, either input
  wire ana_low = (freq_source_code_ff == FS_VOLT_A    && v_low_a) ||
                 (freq_source_code_ff == FS_VOLT_B    && v_low_b) ||
                 (freq_source_code_ff == FS_CURR      && i_low)   ||
                 (freq_source_code_ff == FS_VOLT_CURR && (v_low_b || i_low));
  // Serial source always counts silence; a valid command restarts it
  wire loss_cond = ana_low || ser_src;
  wire restart   = !loss_cond || (ser_src && cmd_kick);
  wire step      = (tick_ff == 32'(TICK_CYC - 1));
  wire loss_now  = (wait_cnt_ff >= loss_wait_time_ff);
  wire loss_rise = loss_now && !loss_ff;

  // R4: count wait steps while condition stays
  // R8: timeout from loss_wait_time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_ff     <= 32'h00000000;
      wait_cnt_ff <= 11'h000;
      loss_ff     <= 1'b0;
    end
    else
    begin
      tick_ff     <= (restart || step) ? 32'h00000000 : tick_ff + 32'h00000001;
      wait_cnt_ff <= restart ? 11'h000 :
                     (step && !loss_now) ? wait_cnt_ff + 11'h001 : wait_cnt_ff;
      loss_ff     <= loss_now && !restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive command selection
  // R14: serial frequency on code 7
  wire [15:0] sel_freq = ser_src ? ser_freq_ff : freq_cmd_input;
  // R13: serial run on code 3
  wire        sel_run  = (run_command_source_ff == RS_SERIAL) ? ser_run_ff : run_input;
  wire        act_stop = loss_ff && (loss_action_select_ff == SCLSUP_ACT_FREERUN ||
                                     loss_action_select_ff == SCLSUP_ACT_DECEL);
  logic [15:0] nxt_freq;
  // R4: action picks output frequency
  always_comb
  begin
    nxt_freq = sel_freq;
    if (loss_ff)
    begin
      unique case (loss_action_select_ff)
        SCLSUP_ACT_KEEP:    nxt_freq = last_freq_ff;
        // R5: continue at preset frequency
        SCLSUP_ACT_PRESET:  nxt_freq = preset_freq_ff;
        default:            nxt_freq = 16'h0000;
      endcase
    end
  end

  // Hold frequency from before loss
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_freq_ff  <= 16'h0000;
      drive_freq_ff <= 16'h0000;
      drive_run_ff  <= 1'b0;
    end
    else
    begin
      last_freq_ff  <= loss_ff ? last_freq_ff : sel_freq;
      drive_freq_ff <= nxt_freq;
      drive_run_ff  <= sel_run && !act_stop;
    end
  end
  assign drive_freq = drive_freq_ff;
  assign drive_run  = drive_run_ff;
  assign output_cut = loss_ff && (loss_action_select_ff == SCLSUP_ACT_FREERUN);
  assign decel_stop = loss_ff && (loss_action_select_ff == SCLSUP_ACT_DECEL);
  // R6: function 11 follows loss
  assign multifunc_output_pin    = loss_ff && (multifunc_output_select_ff == MF_CMD_LOSS);
  assign multifunc_relay_contact = loss_ff && (multifunc_relay_select_ff == MF_CMD_LOSS);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set beats write-one clear
  wire [3:0] int_set = {ser.rx_err, loss_rise, ser.tx_done, ser.rx_valid};
  assign irq = |(int_stat_ff & int_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, sampled in address phase
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (rd_addr)
      A_PROTO:   rd_mux = {31'h0, proto_ff};
      A_BAUD:    rd_mux = {29'h0, baud_ff};
      A_STATION: rd_mux = {24'h0, station_ff};
      A_RUNSRC:  rd_mux = {30'h0, run_command_source_ff};
      A_FRQSRC:  rd_mux = {28'h0, freq_source_code_ff};
      A_CRIT:    rd_mux = {30'h0, loss_criterion_select_ff};
      A_ACTION:  rd_mux = {30'h0, loss_action_select_ff};
      A_WAIT:    rd_mux = {21'h0, loss_wait_time_ff};
      A_MOSEL:   rd_mux = {27'h0, multifunc_output_select_ff};
      A_RLYSEL:  rd_mux = {27'h0, multifunc_relay_select_ff};
      A_VMIN:    rd_mux = {20'h0, voltage_input_min_ff};
      A_VMINB:   rd_mux = {20'h0, voltage_input_min_b_ff};
      A_IMIN:    rd_mux = {20'h0, current_input_min_ff};
      A_PRESET:  rd_mux = {16'h0, preset_freq_ff};
      A_SERFRQ:  rd_mux = {16'h0, ser_freq_ff};
      A_SERCTL:  rd_mux = {31'h0, ser_run_ff};
      A_RXDATA:  rd_mux = {24'h0, rx_data_ff};
      A_STATUS:  rd_mux = {28'h0, drive_run_ff, ser.tx_busy, ser_oe, loss_ff};
      A_INTSTAT: rd_mux = {28'h0, int_stat_ff};
      A_INTMASK: rd_mux = {28'h0, int_mask_ff};
      default:   rd_mux = 32'h00000000;  // Unmapped reads zero
    endcase
  end

  // Bus phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h00000000;
    end
    else
    begin
      wr_pend_ff <= addr_ph && hwrite;
      wr_addr_ff <= addr_ph ? haddr[7:0] : wr_addr_ff;
      hrdata_ff  <= (addr_ph && !hwrite) ? rd_mux : hrdata_ff;
    end
  end

  // Software-written registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      proto_ff                   <= 1'b0;
      // R9: default rate code 3
      baud_ff                    <= BAUD_RST;
      // R12: station number storage
      station_ff                 <= STATION_RST;
      run_command_source_ff      <= 2'h0;
      freq_source_code_ff        <= 4'h0;
      loss_criterion_select_ff   <= 2'h0;
      // R7: no action by default
      loss_action_select_ff      <= 2'h0;
      // R18: wait defaults to 1.0 s
      loss_wait_time_ff          <= WAIT_RST;
      multifunc_output_select_ff <= MO_SEL_RST;
      multifunc_relay_select_ff  <= RELAY_RST;
      voltage_input_min_ff       <= 12'h000;
      voltage_input_min_b_ff     <= 12'h000;
      current_input_min_ff       <= 12'h000;
      preset_freq_ff             <= 16'h0000;
      ser_freq_ff                <= 16'h0000;
      ser_run_ff                 <= 1'b0;
      int_mask_ff                <= 4'h0;
    end
    else if (wr_ph)
    begin
      unique case (wr_addr_ff)
        A_BAUD:    baud_ff                    <= hwdata[2:0];
        A_STATION: station_ff                 <= hwdata[7:0];
        A_RUNSRC:  run_command_source_ff      <= hwdata[1:0];
        A_FRQSRC:  freq_source_code_ff        <= hwdata[3:0];
        A_CRIT:    loss_criterion_select_ff   <= hwdata[1:0];
        A_ACTION:  loss_action_select_ff      <= hwdata[1:0];
        // R18: clamp to 0.1..120 s
        A_WAIT:    loss_wait_time_ff          <= wait_wr;
        A_MOSEL:   multifunc_output_select_ff <= hwdata[4:0];
        A_RLYSEL:  multifunc_relay_select_ff  <= hwdata[4:0];
        A_VMIN:    voltage_input_min_ff       <= hwdata[11:0];
        A_VMINB:   voltage_input_min_b_ff     <= hwdata[11:0];
        A_IMIN:    current_input_min_ff       <= hwdata[11:0];
        A_PRESET:  preset_freq_ff             <= hwdata[15:0];
        A_SERFRQ:  ser_freq_ff                <= hwdata[15:0];
        A_SERCTL:  ser_run_ff                 <= hwdata[0];
        A_INTMASK: int_mask_ff                <= hwdata[3:0];
        default:   proto_ff                   <= wr_proto ? hwdata[0] : proto_ff;
      endcase
    end
  end

  // Hardware-set state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_data_ff  <= 8'h00;
      int_stat_ff <= 4'h0;
    end
    else
    begin
      rx_data_ff  <= ser.rx_valid ? ser.rx_data : rx_data_ff;
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
    end
  end
endmodule : sclsup_top

//--- sclsup_monitor.sv
// Port-level checker for the serial command-loss supervisor
`timescale 1ns/100ps
module sclsup_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ser_out,
  input wire logic        ser_oe,
  input wire logic        output_cut,
  input wire logic        decel_stop,
  input wire logic        drive_run,
  input wire logic [15:0] drive_freq
);
  // One clock domain, so one clocking and one reset guard
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  idle_high_a:
    assert property (!ser_oe |-> ser_out) else $error("line low while released");
  start_bit_a:
    assert property ($rose(ser_oe) |-> (!ser_out) [*8]) else $error("start bit too short");
  stop_bit_a:
    assert property ($fell(ser_oe) |-> $past(ser_out) && $past(ser_out, 2))
      else $error("frame ended without stop level");
  oe_hold_a:
    assert property ($rose(ser_oe) |-> ser_oe [*8]) else $error("driver dropped mid frame");
  // Frequency output lags the action flag by one register stage
  cut_freq_a:
    assert property (output_cut [*2] |-> drive_freq == 16'h0000) else $error("cut left freq");
  cut_run_a:
    assert property (output_cut [*2] |-> !drive_run) else $error("cut left run on");
  decel_end_a:
    assert property (decel_stop [*2] |-> drive_freq == 16'h0000 && !drive_run)
      else $error("decel stop left motion");
  one_action_a:
    assert property (!(output_cut && decel_stop)) else $error("two loss actions at once");
endmodule : sclsup_monitor

//--- sclsup_host.sv
// Bus-master model that sends characters on the shared pair
`timescale 1ns/100ps
module sclsup_host (
  input  wire logic hclk,
  output logic      line
);
  // Idle level is high through the line bias
  // one drive on this segment, within sixteen
  initial line = 1'b1;
  task automatic send(input logic [7:0] b, input int bc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line <= f[i];
      repeat (bc) @(posedge hclk);
    end
  endtask : send
endmodule : sclsup_host

//--- tb.sv
// Self-checking bench for the supervisor top
`timescale 1ns/100ps
module tb;
  import sclsup_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, rd_dp, host_line, hreadyout, hresp, ser_out;
  logic        ser_oe, drive_run, output_cut, decel_stop, mfo, mfr, irq, run;
  logic [1:0]  htrans;
  logic [11:0] volt, curr;
  logic [15:0] fcmd, pr, drive_freq;
  logic [31:0] haddr, hwdata, hrdata, b, exp_q[$];
  int          n_mismatch, n_compared, cyc, len, lq[$];
  integer      seed = 99685;
  // Small parameters keep bit times and wait steps short
  sclsup_top #(.CLK_HZ(192000), .TICK_CYC(10)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .ser_in(ser_oe ? ser_out : host_line), .ser_out, .ser_oe, .analog_voltage_input(volt),
    .analog_current_input(curr), .run_input(run), .freq_cmd_input(fcmd), .drive_freq,
    .drive_run, .output_cut, .decel_stop, .multifunc_output_pin(mfo),
    .multifunc_relay_contact(mfr), .irq);
  sclsup_host i_host (.hclk, .line(host_line));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // Single AHB transfer; holds each phase until ready is seen
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task at(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : at
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Watcher: read data, frame lengths and the hang limit
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
    if (ser_oe === 1'b1) len++;
    else if (len > 0)
    begin
      chk(len, lq.pop_front());
      len = 0;
    end
    rd_dp <= hsel && htrans[1] && !hwrite;
    if (++cyc > 20000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  initial
  begin
    {hresetn, hsel, htrans, haddr, hwrite, hwdata, rd_dp} = '0;
    volt = 12'hFFF; curr = 12'hFFF; run = 1'b1; fcmd = $random(seed); pr = $random(seed);
    at(4);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_BAUD, 3);
    rd(A_ACTION, 0);
    rd(A_WAIT, 10);
    rd(A_PROTO, 0);
    rd(A_STATION, 1);
    chk(drive_run, run);
    bus(A_WAIT, 1, 0); rd(A_WAIT, 1);
    bus(A_WAIT, 1, 32'h7FF); rd(A_WAIT, 32'h4B0);
    bus(A_WAIT, 1, 1); bus(A_BAUD, 1, 4);
    // Both framings, looped back into the receiver
    for (int p = 0; p < 2; p++)
    begin
      b = $random(seed) & 32'hFF; bus(A_PROTO, 1, p); lq.push_back(110 - 10 * p);
      bus(A_TXDATA, 1, b); at(120); rd(A_RXDATA, b);
    end
    chk(hresp, 0); rd(A_INTSTAT, 3); chk(irq, 0); bus(A_INTMASK, 1, 2); at(1); chk(irq, 1);
    bus(A_INTSTAT, 1, 3); at(1); chk(irq, 0); rd(A_INTSTAT, 0);
    b = $random(seed) & 32'hFF; i_host.send(b[7:0], 10); at(2); rd(A_RXDATA, b);
    run <= 1'b0;
    bus(A_RUNSRC, 1, 3); bus(A_FRQSRC, 1, 7); bus(A_SERFRQ, 1, pr); bus(A_SERCTL, 1, 3);
    at(2); chk(drive_run, 1);
    chk(drive_freq, pr);
    at(20); rd(A_STATUS, 9);
    bus(A_FRQSRC, 1, 2); bus(A_VMIN, 1, 32'h100); bus(A_MOSEL, 1, 11);
    bus(A_PRESET, 1, pr); volt <= 12'h0C0;
    for (int c = 0; c < 3; c++)
    begin
      bus(A_CRIT, 1, c); at(20); chk(mfo, c == 2);
    end
    chk(mfr, 0); volt = 12'hFFF; at(5);
    for (int a = 0; a < 4; a++)
    begin
      bus(A_ACTION, 1, a); volt <= 12'h010; at(4); chk(mfo, 0);
      at(16); chk(mfo, 1); chk(output_cut, a == 1); chk(decel_stop, a == 2);
      chk(drive_freq, a == 3 ? pr : a == 0 ? fcmd : 16'h0000);
      volt = 12'hFFF; at(5);
    end
    bus(A_FRQSRC, 1, 6); bus(A_IMIN, 1, 32'h100); bus(A_RLYSEL, 1, 11); curr <= 12'h010;
    at(20); chk(mfo, 1);
    chk(mfr, 1);
    test_done;
  end
endmodule : tb
bind sclsup_top sclsup_monitor i_mon (.hclk, .hresetn, .ser_out, .ser_oe, .output_cut,
  .decel_stop, .drive_run, .drive_freq);
